/* File: bench/ccu_calendar_clock_unit_test.sv */
// testbench for the calendar clock unit
`timescale 1ns/1ps
module ccu_calendar_clock_unit_test;
  reg         mclk = 0, reset_n = 0, xtal_clk = 0, cal_enable = 0, out_select = 1;
  reg         alarm_enable = 0;
  reg   [5:0] alarm_field_en = 0;
  reg   [7:0] cal_value = 0, alarm_sec = 0, alarm_min = 0, alarm_hour = 0;
  reg   [7:0] alarm_day = 0, alarm_month = 0;
  reg   [2:0] alarm_wday = 0;
  wire  [7:0] sec, min, hour, day, month, year;
  wire  [2:0] wday;
  wire        half_sec, alarm_event, clk_out;
  integer     err_count = 0, n_checks = 0, seed = 73545, cyc = 0, t0 = 0;
  reg         xdiv = 0;
  ccu_calendar_clock_unit #(.XTAL_DIV(16'h0040), .XTAL_HALF(16'h0020))
    ccu_calendar_clock_unit_inst (.*);
  initial forever #5 mclk = ~mclk;
  // crystal run fast, one rise per four clocks, short divider
  always @(posedge mclk) begin
    xdiv <= #1 ~xdiv;
    if (xdiv) xtal_clk <= #1 ~xtal_clk;
  end
  function [7:0] bcd_inc(input [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      results;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    #1 reset_n = 1;
    t0 = cyc;
    check({year, month, day, hour, min, sec}, 48'h0001_0100_0000);
    check(wday, 3'h6);
    // random fields that are not compared
    cal_value = $random(seed);
    alarm_min = $random(seed);
    alarm_hour = $random(seed);
    alarm_day = $random(seed);
    alarm_month = $random(seed);
    alarm_wday = $random(seed);
    alarm_sec = bcd_inc(8'h00);
    alarm_field_en = 6'h01;
    alarm_enable = 1;
    $display("reset test done");
    while (!half_sec && cyc < t0 + 400) begin @(posedge mclk); #1; end
    check(cyc - t0 > 120 && cyc - t0 < 140, 1);
    repeat (3) @(posedge mclk);
    #1 check(clk_out, 1);
    out_select = 0;
    repeat (3) @(posedge mclk);
    #1 check(clk_out, 0);
    $display("half second test done");
    while (sec === 8'h00 && cyc < t0 + 600) begin @(posedge mclk); #1; end
    check(cyc - t0 > 250 && cyc - t0 < 270, 1);
    check(sec, bcd_inc(8'h00));
    check({hour, min, half_sec}, 0);
    $display("second tick test done");
    @(posedge mclk);
    #1 check(alarm_event, 1);
    @(posedge mclk);
    #1 check({alarm_event, clk_out}, 2'b01);
    $display("alarm test done");
    while (min === 8'h00 && cyc < t0 + 16000) begin @(posedge mclk); #1; end
    check(cyc - t0 > 15340 && cyc - t0 < 15400, 1);
    check({hour, min, sec}, 24'h00_0100);
    $display("minute carry test done");
    results;
  end
endmodule // ccu_calendar_clock_unit_test
bind ccu_calendar_clock_unit ccu_clock_sva ccu_clock_sva_inst (.*);

/* File: bench/ccu_clock_sva.sv */
// assertion checker for the calendar clock unit
`timescale 1ns/1ps
module ccu_clock_sva (
  input wire       mclk,
  input wire       reset_n,
  input wire       out_select,
  input wire       alarm_enable,
  input wire [5:0] alarm_field_en,
  input wire [7:0] alarm_sec,
  input wire [7:0] sec,
  input wire [7:0] min,
  input wire [7:0] hour,
  input wire [2:0] wday,
  input wire [7:0] day,
  input wire [7:0] month,
  input wire [7:0] year,
  input wire       half_sec,
  input wire       alarm_event,
  input wire       clk_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_event_single: assert property (alarm_event |=> !alarm_event)
    else $error("alarm event too long");
  a_event_enabled: assert property (alarm_event |-> $past(alarm_enable))
    else $error("alarm event while disabled");
  a_event_match: assert property (alarm_event && $past(alarm_field_en[0])
    |-> sec == $past(alarm_sec)) else $error("alarm event on wrong second");
  a_sec_step: assert property ($changed(sec) |-> sec == 8'h00 || sec ==
    (($past(sec[3:0]) == 4'h9) ? {$past(sec[7:4]) + 4'h1, 4'h0} : $past(sec) + 8'h01))
    else $error("seconds skipped");
  a_min_carry: assert property ($changed(min) |-> sec == 8'h00)
    else $error("minutes moved off the carry");
  a_hour_range: assert property (hour <= 8'h23 && hour[3:0] <= 4'h9)
    else $error("hour out of range");
  a_sec_bcd: assert property (sec <= 8'h59 && sec[3:0] <= 4'h9)
    else $error("seconds not bcd");
  a_wday_step: assert property ($changed(day) |-> $changed(wday))
    else $error("weekday did not step");
  a_date_range: assert property (month >= 8'h01 && month <= 8'h12 && day >= 8'h01
    && day <= 8'h31 && year[3:0] <= 4'h9) else $error("date out of range");
  a_pin_select: assert property (out_select && $past(out_select) && $stable(half_sec)
    && $past(half_sec) == $past(half_sec, 2) |-> clk_out == half_sec)
    else $error("pin does not follow half second");
endmodule // ccu_clock_sva

/* File: hw/ccu_bcd_digit.v */
// bcd two-digit counter with carry
`timescale 1ns/1ps
module ccu_bcd_digit (
  input  wire [7:0] val,
  input  wire [7:0] max_val,
  input  wire [7:0] min_val,
  output reg  [7:0] next_val,
  output reg        wrap
);
  always @* begin
    wrap = (val >= max_val);
    if (wrap) begin
      next_val = min_val;
    end else if (val[3:0] == 4'h9) begin
      next_val = {val[7:4] + 4'h1, 4'h0};
    end else begin
      next_val = {val[7:4], val[3:0] + 4'h1};
    end
  end
endmodule // ccu_bcd_digit

/* File: hw/ccu_calendar_clock_unit.v */
// calendar clock unit: time, date, calibration, alarm and output pin
`timescale 1ns/1ps
`include "ccu_defs.vh"
module ccu_calendar_clock_unit #(
  parameter [15:0] XTAL_DIV  = `CCU_XTAL_DIV,
  parameter [15:0] XTAL_HALF = `CCU_XTAL_HALF
) (
  input  wire       mclk,
  input  wire       reset_n,
  input  wire       xtal_clk,
  input  wire       cal_enable,
  input  wire [7:0] cal_value,
  input  wire       out_select,
  input  wire       alarm_enable,
  input  wire [5:0] alarm_field_en,
  input  wire [7:0] alarm_sec,
  input  wire [7:0] alarm_min,
  input  wire [7:0] alarm_hour,
  input  wire [2:0] alarm_wday,
  input  wire [7:0] alarm_day,
  input  wire [7:0] alarm_month,
  output reg  [7:0] sec,
  output reg  [7:0] min,
  output reg  [7:0] hour,
  output reg  [2:0] wday,
  output reg  [7:0] day,
  output reg  [7:0] month,
  output reg  [7:0] year,
  output reg        half_sec,
  output reg        alarm_event,
  output reg        clk_out
);
  reg  [2:0]  xtal_sync;
  reg         xtal_level;
  reg  [15:0] div_cnt;
  reg  [7:0]  minute_cnt;
  reg         sec_tick;
  reg         sec_upd;
  reg  [7:0]  alarm_cnt;
  reg  [7:0]  last_day;
  wire        xtal_rise;
  wire [15:0] div_limit;
  wire [7:0]  nx_sec;
  wire [7:0]  nx_min;
  wire [7:0]  nx_hour;
  wire [7:0]  nx_day;
  wire [7:0]  nx_month;
  wire [7:0]  nx_year;
  wire        w_sec;
  wire        w_min;
  wire        w_hour;
  wire        w_day;
  wire        w_month;
  wire        w_year;
  wire        leap;
  wire        match;
  // second and third stages agree on rise
  assign xtal_rise = (xtal_sync[2:1] == 2'b01) ? 1'b0 : (xtal_sync[1] & xtal_sync[2] & ~xtal_level);
  // once a minute shorten or stretch the second
  assign div_limit = (cal_enable && minute_cnt == 8'h00)
                   ? (XTAL_DIV + {{6{cal_value[7]}}, cal_value, 2'b00})
                   : XTAL_DIV;
  // bcd year divisible by four (2000 included)
  assign leap = (year[4] == 1'b0) ? (year[1:0] == 2'b00) : (year[1:0] == 2'b10);
  always @* begin
    if (month == `CCU_FEB) begin
      last_day = leap ? `CCU_DAYS_29 : `CCU_DAYS_28;
    end else if (month == `CCU_APR || month == `CCU_JUN ||
                 month == `CCU_SEP || month == `CCU_NOV) begin
      last_day = `CCU_DAYS_30;
    end else begin
      last_day = `CCU_DAYS_31;
    end
  end
  ccu_bcd_digit u_sec (.val(sec), .max_val(`CCU_SEC_MAX), .min_val(8'h00),
    .next_val(nx_sec), .wrap(w_sec));
  ccu_bcd_digit u_min (.val(min), .max_val(`CCU_MIN_MAX), .min_val(8'h00),
    .next_val(nx_min), .wrap(w_min));
  ccu_bcd_digit u_hour (.val(hour), .max_val(`CCU_HOUR_MAX), .min_val(8'h00),
    .next_val(nx_hour), .wrap(w_hour));
  ccu_bcd_digit u_day (.val(day), .max_val(last_day), .min_val(`CCU_RST_DAY),
    .next_val(nx_day), .wrap(w_day));
  ccu_bcd_digit u_month (.val(month), .max_val(`CCU_MONTH_MAX), .min_val(`CCU_RST_MONTH),
    .next_val(nx_month), .wrap(w_month));
  ccu_bcd_digit u_year (.val(year), .max_val(`CCU_YEAR_MAX), .min_val(`CCU_RST_YEAR),
    .next_val(nx_year), .wrap(w_year));
  assign match = (~alarm_field_en[0] | (sec == alarm_sec)) &
                 (~alarm_field_en[1] | (min == alarm_min)) &
                 (~alarm_field_en[2] | (hour == alarm_hour)) &
                 (~alarm_field_en[3] | (wday == alarm_wday)) &
                 (~alarm_field_en[4] | (day == alarm_day)) &
                 (~alarm_field_en[5] | (month == alarm_month));
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_sync  <= 3'h0;
      xtal_level <= 1'b0;
      div_cnt    <= 16'h0000;
      minute_cnt <= 8'h00;
      sec_tick   <= 1'b0;
      half_sec   <= 1'b0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], xtal_clk};
      if (xtal_sync[2] == xtal_sync[1]) begin
        xtal_level <= xtal_sync[2];
      end
      sec_tick <= 1'b0;
      if (xtal_rise) begin
        // divide by 32768, half flag at midpoint
        if (div_cnt + 16'h0001 >= div_limit) begin
          div_cnt  <= 16'h0000;
          half_sec <= 1'b0;
          sec_tick <= 1'b1;
          minute_cnt <= (minute_cnt + 8'h01 >= `CCU_CAL_PERIOD) ? 8'h00 : minute_cnt + 8'h01;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
          if (div_cnt + 16'h0001 == XTAL_HALF) begin
            half_sec <= 1'b1;
          end
        end
      end
    end
  end
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sec   <= 8'h00;
      min   <= 8'h00;
      hour  <= 8'h00;
      wday  <= `CCU_RST_WDAY;
      day   <= `CCU_RST_DAY;
      month <= `CCU_RST_MONTH;
      year  <= `CCU_RST_YEAR;
    end else if (sec_tick) begin
      sec <= nx_sec;
      if (w_sec) begin
        min <= nx_min;
        if (w_min) begin
          hour <= nx_hour;
          if (w_hour) begin
            wday <= (wday == `CCU_WDAY_MAX) ? 3'h0 : wday + 3'h1;
            day  <= nx_day;
            if (w_day) begin
              month <= nx_month;
              if (w_month) begin
                year <= nx_year;
              end
            end
          end
        end
      end
    end
  end
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_event <= 1'b0;
      alarm_cnt   <= 8'h00;
      clk_out     <= 1'b0;
      sec_upd     <= 1'b0;
    end else begin
      // compare against the freshly updated time
      sec_upd <= sec_tick;
      // one pulse on the matching second
      alarm_event <= sec_upd & alarm_enable & match;
      if (alarm_event) begin
        alarm_cnt <= `CCU_ALARM_PULSE;
      end else if (sec_tick && alarm_cnt != 8'h00) begin
        alarm_cnt <= alarm_cnt - 8'h01;
      end
      if (out_select == `CCU_OUT_ALARM) begin
        clk_out <= alarm_event | (alarm_cnt != 8'h00);
      end else begin
        clk_out <= half_sec;
      end
    end
  end
endmodule // ccu_calendar_clock_unit

/* File: hw/ccu_defs.vh */
// constants for the calendar clock unit
`ifndef CCU_DEFS_VH
`define CCU_DEFS_VH
`define CCU_XTAL_DIV      16'h8000
`define CCU_XTAL_HALF     16'h4000
`define CCU_CAL_PERIOD    8'h3C
`define CCU_CAL_STEP      16'h0004
`define CCU_SEC_MAX       8'h59
`define CCU_MIN_MAX       8'h59
`define CCU_HOUR_MAX      8'h23
`define CCU_WDAY_MAX      3'h6
`define CCU_MONTH_MAX     8'h12
`define CCU_YEAR_MAX      8'h99
`define CCU_RST_DAY       8'h01
`define CCU_RST_MONTH     8'h01
`define CCU_RST_YEAR      8'h00
`define CCU_RST_WDAY      3'h6
`define CCU_FEB           8'h02
`define CCU_APR           8'h04
`define CCU_JUN           8'h06
`define CCU_SEP           8'h09
`define CCU_NOV           8'h11
`define CCU_DAYS_31       8'h31
`define CCU_DAYS_30       8'h30
`define CCU_DAYS_29       8'h29
`define CCU_DAYS_28       8'h28
`define CCU_OUT_ALARM     1'b0
`define CCU_ALARM_PULSE   8'h01
`endif
